/* inc/efr_pkg.sv */
// constants and types for the enhanced feature control block
// assumes the register bank decodes the channel and hands in a 3-bit offset
package efr_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [2:0] EFR_OFFSET = 3'h2;
	localparam logic [7:0] EFR_RESET = 8'h00;
	localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
	localparam int SFR_GATE_BIT = 2;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int EFR_AUTO_CTS_BIT = 7;
	localparam int EFR_AUTO_RTS_BIT = 6;
	localparam int EFR_SPECIAL_BIT = 5;
	localparam int EFR_ENH_BIT = 4;
	localparam int EFR_SWFC_MSB = 3;
	localparam int EFR_SWFC_LSB = 0;
	localparam logic [1:0] SWFC_NONE = 2'h0;
	localparam logic [1:0] SWFC_FIRST = 2'h2;
	localparam logic [1:0] SWFC_SECOND = 2'h1;
	localparam logic [1:0] SWFC_BOTH = 2'h3;
	// ************************************************************
	// write masks for the enhanced-function gate
	// ************************************************************
	localparam logic [7:0] FULL_WMASK = 8'hFF;
	localparam logic [7:0] IER_BASE_WMASK = 8'h0F;
	localparam logic [7:0] FCR_BASE_WMASK = 8'hCF;
	localparam logic [7:0] MCR_BASE_WMASK = 8'h1F;
	// ************************************************************
	// interrupt report
	// ************************************************************
	localparam logic [5:0] XOFF_SPECIAL_IID = 6'h10;
	localparam logic [5:0] IID_NONE = 6'h00;
	localparam int XOFF_SPECIAL_PRIORITY = 6;
	localparam int LEVEL_W = 7;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_ON1 = 3'b010,
		SEQ_OFF1 = 3'b100
	} seq_state_e;
endpackage

/* inc/flow_sel_if.sv */
// interface between the control block and its character matcher
// assumes both ends run in one clock domain; all signals are combinational
`timescale 1ns/1ns
interface flow_sel_if;
	logic [3:0] swfc;
	logic [7:0] data;
	logic [7:0] resume_char_first;
	logic [7:0] resume_char_second;
	logic [7:0] halt_char_first;
	logic [7:0] halt_char_second;
	logic eq_on1;
	logic eq_on2;
	logic eq_off1;
	logic eq_off2;
	logic cmp_first;
	logic cmp_second;
	logic rx_double;
	logic tx_first;
	logic tx_second;
	modport matcher (
		input swfc, data, resume_char_first, resume_char_second, halt_char_first, halt_char_second,
		output eq_on1, eq_on2, eq_off1, eq_off2, cmp_first, cmp_second,
		output rx_double, tx_first, tx_second
	);
	modport user (
		output swfc, data, resume_char_first, resume_char_second, halt_char_first, halt_char_second,
		input eq_on1, eq_on2, eq_off1, eq_off2, cmp_first, cmp_second,
		input rx_double, tx_first, tx_second
	);
endinterface

/* hw/flow_char_match.sv */
// decodes the software flow control field and compares a received character
// assumes the character registers are stable while a character is evaluated
`timescale 1ns/1ns
module flow_char_match (
	flow_sel_if.matcher sel
);
	logic [1:0] tx_code;
	logic [1:0] rx_code;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	assign tx_code = sel.swfc[3:2];
	assign rx_code = sel.swfc[1:0];

	// ************************************************************
	// raw comparisons
	// ************************************************************
	assign sel.eq_on1 = hit(sel.data, sel.resume_char_first);
	assign sel.eq_on2 = hit(sel.data, sel.resume_char_second);
	assign sel.eq_off1 = hit(sel.data, sel.halt_char_first);
	assign sel.eq_off2 = hit(sel.data, sel.halt_char_second);

	// ************************************************************
	// field decode
	// ************************************************************
	// transmit side
	assign sel.tx_first = (tx_code == efr_pkg::SWFC_FIRST) || (tx_code == efr_pkg::SWFC_BOTH);
	assign sel.tx_second = (tx_code == efr_pkg::SWFC_SECOND) || (tx_code == efr_pkg::SWFC_BOTH);

	// single-char receive: 11 with one tx pair means either pair
	always_comb begin
		sel.cmp_first = 1'b0;
		sel.cmp_second = 1'b0;
		sel.rx_double = 1'b0;
		case (rx_code)
			efr_pkg::SWFC_FIRST: begin
				sel.cmp_first = 1'b1;
			end
			efr_pkg::SWFC_SECOND: begin
				sel.cmp_second = 1'b1;
			end
			efr_pkg::SWFC_BOTH: begin
				if (tx_code == efr_pkg::SWFC_FIRST || tx_code == efr_pkg::SWFC_SECOND) begin
					sel.cmp_first = 1'b1;
					sel.cmp_second = 1'b1;
				end else begin
					sel.rx_double = 1'b1;
				end
			end
			default: begin
				sel.cmp_first = 1'b0;
			end
		endcase
	end
endmodule

/* hw/uart_enhanced_feature_control.sv */
// enhanced feature control for one serial channel
// assumes the register bank supplies offset, strobes, line format and special
// function values; flow control characters and fifo levels come from same clock
`timescale 1ns/1ns

// Functional notes
// - register visible only under key, resets zero
// - auto-CTS bit gates transmit start
// - auto-RTS bit drives RTS, else manual
// - special char stored, detection flagged
// - compared second halt char acts, not stored
// - enhanced bit gates writes and sleep
// - upper field bits pick transmit pairs
// - lower field bits pick receive compare
// - double codes need two-character sequences
// - enhanced enable is bit four
// - halt/special reported with code 010000
module uart_enhanced_feature_control (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [2:0] I_ADDR,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [7:0] I_WDATA,
	output logic [7:0] O_RDATA,
	output logic O_RD_HIT,
	input wire logic [7:0] I_LINE_FORMAT_CTRL,
	input wire logic [7:0] I_SPECIAL_FUNCTION_CTRL,
	input wire logic [7:0] I_RESUME_CHAR_FIRST,
	input wire logic [7:0] I_RESUME_CHAR_SECOND,
	input wire logic [7:0] I_HALT_CHAR_FIRST,
	input wire logic [7:0] I_HALT_CHAR_SECOND,
	input wire logic I_CTS_N,
	input wire logic I_MANUAL_RTS,
	input wire logic [6:0] I_RX_LEVEL,
	input wire logic [6:0] I_RTS_HALT_LEVEL,
	input wire logic [6:0] I_RTS_RESUME_LEVEL,
	output logic O_RTS_N,
	output logic O_TX_START_OK,
	output logic O_TX_SEND_FIRST,
	output logic O_TX_SEND_SECOND,
	input wire logic I_RX_VALID,
	input wire logic [7:0] I_RX_DATA,
	output logic O_RX_PUSH,
	output logic [7:0] O_RX_PUSH_DATA,
	output logic O_XON_SEEN,
	output logic O_XOFF_SEEN,
	output logic O_SPECIAL_SEEN,
	input wire logic I_IID_READ,
	output logic [5:0] O_IID_CODE,
	output logic O_ENH_EN,
	output logic [7:0] O_IER_WMASK,
	output logic [7:0] O_FCR_WMASK,
	output logic [7:0] O_MCR_WMASK,
	output logic O_TCR_TLR_WEN,
	output logic O_SLEEP_ALLOW
);
	logic [7:0] efr_r;
	logic sel;
	logic cts_meta_r;
	logic cts_sync_r;
	logic rts_hold_r;
	logic rts_n_r;
	logic halted_r;
	logic tx_first_r;
	logic tx_second_r;
	logic pend_r;
	efr_pkg::seq_state_e seq_r;
	efr_pkg::seq_state_e seq_nxt;
	logic [7:0] held_r;
	logic replay_v_r;
	logic [7:0] replay_d_r;
	logic in_v;
	logic [7:0] in_d;
	logic push_nxt;
	logic [7:0] push_d_nxt;
	logic xon_nxt;
	logic xoff_nxt;
	logic spec_nxt;
	logic hold_nxt;
	logic replay_nxt;
	logic push_r;
	logic [7:0] push_d_r;
	logic xon_r;
	logic xoff_r;
	logic spec_r;
	logic enh;
	logic special_en;
	flow_sel_if fsel ();

	flow_char_match u_match (
		.sel(fsel)
	);

	// ************************************************************
	// register access
	// ************************************************************
	assign sel = (I_LINE_FORMAT_CTRL == efr_pkg::LCR_ENH_KEY) &&
		!I_SPECIAL_FUNCTION_CTRL[efr_pkg::SFR_GATE_BIT];

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			efr_r <= efr_pkg::EFR_RESET;
		end else if (I_WR && sel && I_ADDR == efr_pkg::EFR_OFFSET) begin
			efr_r <= I_WDATA;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
			O_RD_HIT <= 1'b0;
		end else begin
			O_RD_HIT <= I_RD && sel && I_ADDR == efr_pkg::EFR_OFFSET;
			O_RDATA <= (I_RD && sel && I_ADDR == efr_pkg::EFR_OFFSET) ? efr_r : 8'h00;
		end
	end

	// ************************************************************
	// enhanced-function gate
	// ************************************************************
	assign enh = efr_r[efr_pkg::EFR_ENH_BIT];
	assign special_en = efr_r[efr_pkg::EFR_SPECIAL_BIT];
	assign O_ENH_EN = enh;
	assign O_IER_WMASK = enh ? efr_pkg::FULL_WMASK : efr_pkg::IER_BASE_WMASK;
	assign O_FCR_WMASK = enh ? efr_pkg::FULL_WMASK : efr_pkg::FCR_BASE_WMASK;
	assign O_MCR_WMASK = enh ? efr_pkg::FULL_WMASK : efr_pkg::MCR_BASE_WMASK;
	assign O_TCR_TLR_WEN = enh;
	assign O_SLEEP_ALLOW = enh;

	// ************************************************************
	// hardware flow control
	// ************************************************************
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cts_meta_r <= 1'b1;
			cts_sync_r <= 1'b1;
		end else begin
			cts_meta_r <= I_CTS_N;
			cts_sync_r <= cts_meta_r;
		end
	end

	// hysteresis avoids RTS chatter around one level
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rts_hold_r <= 1'b0;
		end else if (I_RX_LEVEL >= I_RTS_HALT_LEVEL) begin
			rts_hold_r <= 1'b1;
		end else if (I_RX_LEVEL <= I_RTS_RESUME_LEVEL) begin
			rts_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rts_n_r <= 1'b1;
		end else if (efr_r[efr_pkg::EFR_AUTO_RTS_BIT]) begin
			rts_n_r <= rts_hold_r;
		end else begin
			rts_n_r <= !I_MANUAL_RTS;
		end
	end
	assign O_RTS_N = rts_n_r;

	// starts only; a character already shifting out finishes
	assign O_TX_START_OK = (!efr_r[efr_pkg::EFR_AUTO_CTS_BIT] || !cts_sync_r) &&
		!(halted_r && fsel.swfc[1:0] != efr_pkg::SWFC_NONE);

	// ************************************************************
	// software flow control select
	// ************************************************************
	assign fsel.swfc = efr_r[efr_pkg::EFR_SWFC_MSB:efr_pkg::EFR_SWFC_LSB];
	assign fsel.data = in_d;
	assign fsel.resume_char_first = I_RESUME_CHAR_FIRST;
	assign fsel.resume_char_second = I_RESUME_CHAR_SECOND;
	assign fsel.halt_char_first = I_HALT_CHAR_FIRST;
	assign fsel.halt_char_second = I_HALT_CHAR_SECOND;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			tx_first_r <= 1'b0;
			tx_second_r <= 1'b0;
		end else begin
			tx_first_r <= fsel.tx_first;
			tx_second_r <= fsel.tx_second;
		end
	end
	assign O_TX_SEND_FIRST = tx_first_r;
	assign O_TX_SEND_SECOND = tx_second_r;

	// ************************************************************
	// receive character handling
	// ************************************************************
	// a replayed character has priority; next char assumed not in the following cycle
	assign in_v = I_RX_VALID || replay_v_r;
	assign in_d = replay_v_r ? replay_d_r : I_RX_DATA;

	always_comb begin
		seq_nxt = seq_r;
		push_nxt = 1'b0;
		push_d_nxt = in_d;
		xon_nxt = 1'b0;
		xoff_nxt = 1'b0;
		spec_nxt = 1'b0;
		hold_nxt = 1'b0;
		replay_nxt = 1'b0;
		if (!fsel.rx_double) begin
			seq_nxt = efr_pkg::SEQ_IDLE;
			if (in_v) begin
				if ((fsel.eq_on1 && fsel.cmp_first) || (fsel.eq_on2 && fsel.cmp_second)) begin
					xon_nxt = 1'b1;
				end else if (fsel.eq_off1 && fsel.cmp_first) begin
					xoff_nxt = 1'b1;
				end else if (fsel.eq_off2 && fsel.cmp_second) begin
					xoff_nxt = 1'b1;
					spec_nxt = special_en;
				end else begin
					push_nxt = 1'b1;
					spec_nxt = special_en && fsel.eq_off2;
				end
			end
		end else begin
			case (seq_r)
				efr_pkg::SEQ_IDLE: begin
					if (in_v && fsel.eq_on1) begin
						hold_nxt = 1'b1;
						seq_nxt = efr_pkg::SEQ_ON1;
					end else if (in_v && fsel.eq_off1) begin
						hold_nxt = 1'b1;
						seq_nxt = efr_pkg::SEQ_OFF1;
					end else if (in_v) begin
						push_nxt = 1'b1;
						spec_nxt = special_en && fsel.eq_off2;
					end
				end
				efr_pkg::SEQ_ON1, efr_pkg::SEQ_OFF1: begin
					if (in_v) begin
						seq_nxt = efr_pkg::SEQ_IDLE;
						if (seq_r == efr_pkg::SEQ_ON1 && fsel.eq_on2) begin
							xon_nxt = 1'b1;
						end else if (seq_r == efr_pkg::SEQ_OFF1 && fsel.eq_off2) begin
							xoff_nxt = 1'b1;
							spec_nxt = special_en;
						end else begin
							// broken sequence: release the held first char, retry this one
							push_nxt = 1'b1;
							push_d_nxt = held_r;
							replay_nxt = 1'b1;
						end
					end
				end
				default: begin
					seq_nxt = efr_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			seq_r <= efr_pkg::SEQ_IDLE;
			held_r <= 8'h00;
			replay_v_r <= 1'b0;
			replay_d_r <= 8'h00;
		end else begin
			seq_r <= seq_nxt;
			held_r <= hold_nxt ? in_d : held_r;
			replay_v_r <= replay_nxt;
			replay_d_r <= replay_nxt ? in_d : replay_d_r;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			push_r <= 1'b0;
			push_d_r <= 8'h00;
			xon_r <= 1'b0;
			xoff_r <= 1'b0;
			spec_r <= 1'b0;
		end else begin
			push_r <= push_nxt;
			push_d_r <= push_d_nxt;
			xon_r <= xon_nxt;
			xoff_r <= xoff_nxt;
			spec_r <= spec_nxt;
		end
	end
	assign O_RX_PUSH = push_r;
	assign O_RX_PUSH_DATA = push_d_r;
	assign O_XON_SEEN = xon_r;
	assign O_XOFF_SEEN = xoff_r;
	assign O_SPECIAL_SEEN = spec_r;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			halted_r <= 1'b0;
		end else if (fsel.swfc[1:0] == efr_pkg::SWFC_NONE || xon_nxt) begin
			halted_r <= 1'b0;
		end else if (xoff_nxt) begin
			halted_r <= 1'b1;
		end
	end

	// ************************************************************
	// interrupt report
	// ************************************************************
	// set beats a same-cycle read so no event is lost
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pend_r <= 1'b0;
		end else if (enh && (xoff_nxt || spec_nxt)) begin
			pend_r <= 1'b1;
		end else if (I_IID_READ) begin
			pend_r <= 1'b0;
		end
	end
	assign O_IID_CODE = (pend_r && enh) ? efr_pkg::XOFF_SPECIAL_IID : efr_pkg::IID_NONE;
endmodule

/* verification/efr_chk.sv */
// assertions on the enhanced feature control ports
// assumes a bind from the bench; one clock, sync active-high reset
`timescale 1ns/1ns
module efr_chk (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [2:0] I_ADDR,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [7:0] I_WDATA,
	input wire logic [7:0] I_LINE_FORMAT_CTRL,
	input wire logic [7:0] I_SPECIAL_FUNCTION_CTRL,
	input wire logic I_CTS_N,
	input wire logic I_MANUAL_RTS,
	input wire logic [6:0] I_RX_LEVEL,
	input wire logic [6:0] I_RTS_HALT_LEVEL,
	input wire logic [7:0] O_RDATA,
	input wire logic O_RD_HIT,
	input wire logic O_RTS_N,
	input wire logic O_TX_START_OK,
	input wire logic O_TX_SEND_FIRST,
	input wire logic O_TX_SEND_SECOND,
	input wire logic O_XOFF_SEEN,
	input wire logic [5:0] O_IID_CODE,
	input wire logic O_ENH_EN,
	input wire logic [7:0] O_FCR_WMASK,
	input wire logic [7:0] O_IER_WMASK,
	input wire logic [7:0] O_MCR_WMASK,
	input wire logic O_TCR_TLR_WEN,
	input wire logic O_SLEEP_ALLOW
);
	logic key;
	logic sel;
	logic [7:0] efr_r;
	assign key = I_LINE_FORMAT_CTRL == efr_pkg::LCR_ENH_KEY && !I_SPECIAL_FUNCTION_CTRL[2];
	assign sel = key && I_ADDR == efr_pkg::EFR_OFFSET;
	// shadow of the register, so checks need no internal probes
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			efr_r <= 8'h00;
		end else if (I_WR && sel) begin
			efr_r <= I_WDATA;
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// ********
	// checks
	// ********
	chk_read_hit: assert property (I_RD && sel |=> O_RD_HIT && O_RDATA == efr_r)
		else $error("register read wrong");
	chk_read_miss: assert property (I_RD && !sel |=> !O_RD_HIT && O_RDATA == 8'h00)
		else $error("locked read answered");
	chk_gate_masks: assert property (O_ENH_EN == efr_r[4] && O_SLEEP_ALLOW == efr_r[4]
		&& O_TCR_TLR_WEN == efr_r[4]
		&& O_FCR_WMASK == (efr_r[4] ? efr_pkg::FULL_WMASK : efr_pkg::FCR_BASE_WMASK)
		&& O_IER_WMASK == (efr_r[4] ? efr_pkg::FULL_WMASK : efr_pkg::IER_BASE_WMASK)
		&& O_MCR_WMASK == (efr_r[4] ? efr_pkg::FULL_WMASK : efr_pkg::MCR_BASE_WMASK))
		else $error("enhanced gate wrong");
	chk_manual_rts: assert property (!efr_r[6] |=> O_RTS_N == !$past(I_MANUAL_RTS))
		else $error("manual rts not followed");
	chk_auto_rts: assert property ((efr_r[6] && I_RX_LEVEL >= I_RTS_HALT_LEVEL)[*2]
		|=> O_RTS_N)
		else $error("rts not dropped at threshold");
	chk_cts_stall: assert property ((efr_r[7] && I_CTS_N)[*4] |-> !O_TX_START_OK)
		else $error("transmit not stalled");
	chk_cts_free: assert property ((!efr_r[7] && efr_r[1:0] == 2'h0)[*2]
		|-> O_TX_START_OK)
		else $error("transmit stalled without cause");
	chk_tx_pairs: assert property ($stable(efr_r)[*2] |-> O_TX_SEND_FIRST == efr_r[3]
		&& O_TX_SEND_SECOND == efr_r[2])
		else $error("transmit pair select wrong");
	chk_xoff_iid: assert property (O_XOFF_SEEN && O_ENH_EN
		|-> O_IID_CODE == efr_pkg::XOFF_SPECIAL_IID)
		else $error("halt interrupt code wrong");
endmodule

/* verification/line_partner.sv */
// model of the remote serial party: sends characters and drives flow pin
// assumes tasks are called just after a rising edge of the clock
`timescale 1ns/1ns
module line_partner (
	input wire logic i_clk,
	output logic o_cts_n,
	output logic o_valid,
	output logic [7:0] o_data
);
	initial begin
		o_cts_n = 1'b0;
		o_valid = 1'b0;
		o_data = 8'h00;
	end
	// one char then a blank cycle keeps the minimum spacing
	task automatic send(input logic [7:0] ch);
		o_valid <= 1'b1;
		o_data <= ch;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_data <= ~ch; // stale byte is not held
		@(posedge i_clk);
	endtask
	task automatic stall(input int n);
		o_cts_n <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_cts_n <= 1'b0;
	endtask
endmodule

/* verification/uart_enhanced_feature_control_tb_top.sv */
// bench for the enhanced feature control block
// assumes the line partner model and the bound checker
`timescale 1ns/1ns
module uart_enhanced_feature_control_tb_top;
	logic I_CLK, I_RST, I_WR, I_RD, I_CTS_N, I_MANUAL_RTS, I_RX_VALID, I_IID_READ;
	logic [2:0] I_ADDR;
	logic [7:0] I_WDATA, I_LINE_FORMAT_CTRL, I_SPECIAL_FUNCTION_CTRL, I_RX_DATA;
	logic [6:0] I_RX_LEVEL, I_RTS_HALT_LEVEL, I_RTS_RESUME_LEVEL;
	logic [7:0] O_RDATA, O_RX_PUSH_DATA, O_IER_WMASK, O_FCR_WMASK, O_MCR_WMASK, ch;
	logic [5:0] O_IID_CODE;
	logic O_RD_HIT, O_RTS_N, O_TX_START_OK, O_TX_SEND_FIRST, O_TX_SEND_SECOND, O_RX_PUSH;
	logic O_XON_SEEN, O_XOFF_SEEN, O_SPECIAL_SEEN, O_ENH_EN, O_TCR_TLR_WEN, O_SLEEP_ALLOW;
	logic [11:0] seen;
	logic [11:0] evq[$];
	logic [7:0] rdq[$];
	int error_cnt, checked;
	uart_enhanced_feature_control dut (
		.I_RESUME_CHAR_FIRST(8'h11),
		.I_RESUME_CHAR_SECOND(8'h12),
		.I_HALT_CHAR_FIRST(8'h13),
		.I_HALT_CHAR_SECOND(8'h14),
		.*
	);
	line_partner u_lp (.i_clk(I_CLK), .o_cts_n(I_CTS_N), .o_valid(I_RX_VALID),
		.o_data(I_RX_DATA));
	initial begin
		I_CLK = 1'b0;
		forever #4 I_CLK = ~I_CLK;
	end
	// ********
	// tasks
	// ********
	task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] d);
		I_ADDR <= 3'h2;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
		@(posedge I_CLK);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic hit);
		if (hit)
			rdq.push_back(e);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		@(posedge I_CLK);
	endtask
	// only chars that raise an event leave a note
	task automatic rx(input logic [7:0] c, input logic [11:0] e);
		if (e[11:8] != 4'h0)
			evq.push_back(e);
		u_lp.send(c);
	endtask
	function automatic logic [11:0] ev(input logic [3:0] c, input logic [7:0] x);
		logic on, off;
		on = (c[1] && x == 8'h11) || (c[0] && x == 8'h12);
		off = (c[1] && x == 8'h13) || (c[0] && x == 8'h14);
		return {!(on || off), on, off, x == 8'h14, (on || off) ? 8'h00 : x};
	endfunction
	// ********
	// result watcher
	// ********
	assign seen = {O_RX_PUSH, O_XON_SEEN, O_XOFF_SEEN, O_SPECIAL_SEEN,
		O_RX_PUSH ? O_RX_PUSH_DATA : 8'h00};
	always @(posedge I_CLK) begin
		if (!I_RST && O_RD_HIT !== 1'b0)
			cmp("efr", rdq.size() ? rdq.pop_front() : 8'hxx, O_RDATA);
		if (!I_RST && seen[11:8] !== 4'h0)
			cmp("rx", evq.size() ? evq.pop_front() : 12'hxxx, seen);
	end
	initial begin
		repeat (20000) @(posedge I_CLK);
		cmp("watchdog", 12'h000, 12'h001);
		report_and_stop();
	end
	initial begin
		I_RST = 1'b1;
		I_ADDR = 3'h2;
		I_WR = 1'b0;
		I_RD = 1'b0;
		I_WDATA = 8'h00;
		I_LINE_FORMAT_CTRL = 8'hBF;
		I_SPECIAL_FUNCTION_CTRL = 8'h00;
		I_MANUAL_RTS = 1'b0;
		I_RX_LEVEL = 7'h00;
		I_RTS_HALT_LEVEL = 7'h3C;
		I_RTS_RESUME_LEVEL = 7'h14;
		I_IID_READ = 1'b0;
		void'($urandom(87270));
		repeat (3) @(posedge I_CLK);
		I_RST <= 1'b0;
		rd(3'h2, 8'h00, 1'b1);
		rd(3'h5, 8'h00, 1'b0);
		I_LINE_FORMAT_CTRL <= 8'h03;
		wr(8'hFF);
		rd(3'h2, 8'h00, 1'b0);
		I_LINE_FORMAT_CTRL <= 8'hBF;
		I_SPECIAL_FUNCTION_CTRL <= 8'h04;
		rd(3'h2, 8'h00, 1'b0);
		I_SPECIAL_FUNCTION_CTRL <= 8'h00;
		rd(3'h2, 8'h00, 1'b1);
		for (int c = 0; c < 16; c++) begin
			// double codes run with special detect off
			ch = (c == 3 || c == 15) ? {4'h1, 4'(c)} : {4'h3, 4'(c)};
			wr(ch);
			rd(3'h2, ch, 1'b1);
			cmp("ier_mask", 12'(efr_pkg::FULL_WMASK), 12'(O_IER_WMASK));
			cmp("mcr_mask", 12'(efr_pkg::FULL_WMASK), 12'(O_MCR_WMASK));
			cmp("tcr_wen", 12'h001, 12'(O_TCR_TLR_WEN));
			if (c == 3 || c == 15) begin
				// broken pair: held char released, second one re-evaluated
				evq.push_back(12'h811);
				rx(8'h11, 12'h000);
				rx(8'h41, 12'h841);
				rx(8'h11, 12'h000);
				rx(8'h12, 12'h400);
				rx(8'h13, 12'h000);
				rx(8'h14, 12'h200);
			end else begin
				for (int i = 0; i < 5; i++) begin
					ch = i < 4 ? 8'(8'h11 + i) : {1'b1, 7'($urandom)};
					rx(ch, ev(4'(c), ch));
				end
			end
		end
		@(posedge I_CLK);
		cmp("iid", 12'(efr_pkg::XOFF_SPECIAL_IID), 12'(O_IID_CODE));
		cmp("txok", 12'h000, 12'(O_TX_START_OK));
		I_IID_READ <= 1'b1;
		@(posedge I_CLK);
		I_IID_READ <= 1'b0;
		repeat (2) @(posedge I_CLK);
		cmp("iid", 12'h000, 12'(O_IID_CODE));
		wr(8'h80);
		cmp("ier_mask", 12'(efr_pkg::IER_BASE_WMASK), 12'(O_IER_WMASK));
		cmp("fcr_mask", 12'(efr_pkg::FCR_BASE_WMASK), 12'(O_FCR_WMASK));
		cmp("mcr_mask", 12'(efr_pkg::MCR_BASE_WMASK), 12'(O_MCR_WMASK));
		cmp("tcr_wen", 12'h000, 12'(O_TCR_TLR_WEN));
		fork
			u_lp.stall(8);
			begin
				repeat (6) @(posedge I_CLK);
				cmp("txok", 12'h000, 12'(O_TX_START_OK));
			end
		join
		repeat (5) @(posedge I_CLK);
		cmp("txok", 12'h001, 12'(O_TX_START_OK));
		wr(8'h40);
		I_RX_LEVEL <= 7'h3C + 7'($urandom_range(3));
		repeat (4) @(posedge I_CLK);
		cmp("rts", 12'h001, 12'(O_RTS_N));
		I_RX_LEVEL <= 7'($urandom_range(20));
		repeat (4) @(posedge I_CLK);
		cmp("rts", 12'h000, 12'(O_RTS_N));
		wr(8'h00);
		repeat (8) begin
			I_MANUAL_RTS <= 1'($urandom);
			@(posedge I_CLK);
		end
		cmp("left", 12'h000, 12'(rdq.size() + evq.size()));
		report_and_stop();
	end
endmodule
bind uart_enhanced_feature_control efr_chk u_chk (.*);
